// ==== codec_gain_consts.vh ====
// register offsets, field positions, reset values and the sidetone clamp limit of the gain/routing bank
// assumes a host write/read port addressed by register index and an audio word clock pin
// Function
// RULE1 - left mute bit silences left playback output
// RULE2 - left volume: 0.5 dB attenuation per code
// RULE3 - right mute at bit 7 silences right
// RULE4 - right volume bits 6:0, 0.5 dB steps
// RULE5 - sidetone mute bit, resets muted
// RULE6 - sidetone gain code 0 is -34.5 dB
// RULE7 - sidetone gain clamps at 12 dB above 1011100
// RULE8 - selector codes 0-3 pick single-ended sources
// RULE9 - selector codes 4-7 pick differential pairs
// RULE10 - differential selection makes sidetone path invalid
// RULE11 - record enable connects selected source to converter
// RULE12 - cellphone bit routes cellphone input, resets off
// RULE13 - sidetone done flag: applied equals programmed; code compares applied with the clamped target instead
// RULE14 - playback steps per word clock, or two
// RULE15 - left/right done flags mark playback completion
// RULE16 - reserved and flag writes ignored, reserved reads zero
// RULE17 - sidetone steps one code per word clock
`ifndef CODEC_GAIN_CONSTS_VH
`define CODEC_GAIN_CONSTS_VH

`define REG_ADDR_W 4
`define REG_DATA_W 16
`define GAIN_W 7

`define ADDR_PLAY_GAIN 4'h2
`define ADDR_MIX_ROUTE 4'h3

`define PLAY_LEFT_MUTE_BIT 15
`define PLAY_LEFT_VOL_HI 14
`define PLAY_LEFT_VOL_LO 8
`define PLAY_RIGHT_MUTE_BIT 7
`define PLAY_RIGHT_VOL_HI 6
`define PLAY_RIGHT_VOL_LO 0

`define MIX_ST_MUTE_BIT 15
`define MIX_ST_GAIN_HI 14
`define MIX_ST_GAIN_LO 8
`define MIX_SEL_HI 7
`define MIX_SEL_LO 5
`define MIX_REC_EN_BIT 4
`define MIX_CELL_BIT 3
`define MIX_ST_DONE_BIT 0

`define RST_PLAY_MUTE 1'b1
`define RST_PLAY_VOL 7'h7f
`define RST_ST_MUTE 1'b1
`define RST_ST_GAIN 7'h45
`define RST_SEL 3'h0
`define RST_REC_EN 1'b0
`define RST_CELL 1'b0

`define ST_GAIN_MAX 7'h5d

`endif

// ==== wclk_tick.v ====
// word clock pin synchroniser and soft-step rate enables
// assumes the word clock is far slower than the system clock
`timescale 1ns/10ps
module wclk_tick (
  input wire i_clk,
  input wire i_rst,
  input wire i_wclk,
  input wire i_slow,
  output reg o_tick_fast,
  output reg o_tick_play
);
  reg meta_q;
  reg sync_q;
  reg last_q;
  reg half_q;
  wire rise;

  // only sync_q and last_q feed the edge detector; meta_q stays private
  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= i_wclk;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      half_q <= 1'b0;
      o_tick_fast <= 1'b0;
      o_tick_play <= 1'b0;
    end else begin
      o_tick_fast <= rise;
      if (rise) begin
        half_q <= ~half_q;
      end
      o_tick_play <= rise & (~i_slow | half_q); // [RULE14]
    end
  end
endmodule

// ==== gain_stepper.v ====
// one soft-stepped gain code that walks toward its target one code per enable
// assumes the target is already limited to the legal range
`timescale 1ns/10ps
module gain_stepper #(
  parameter W = 7,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_step,
  input wire [W-1:0] i_target,
  output reg [W-1:0] o_applied,
  output wire o_done
);
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_applied <= INIT;
    end else if (i_step) begin
      if (o_applied < i_target) begin
        o_applied <= o_applied + {{(W-1){1'b0}}, 1'b1};
      end else if (o_applied > i_target) begin
        o_applied <= o_applied - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  assign o_done = (o_applied == i_target);
endmodule

// ==== codec_gain_regs.v ====
// playback gain and mixer routing control registers with soft-stepped gains
// assumes a single-cycle host write/read port on I_SYS_CLK and an asynchronous word clock pin
`timescale 1ns/10ps
`include "codec_gain_consts.vh"
module codec_gain_regs (
  input wire I_SYS_CLK,
  input wire I_RST,
  input wire [`REG_ADDR_W-1:0] I_REG_ADDR,
  input wire [`REG_DATA_W-1:0] I_REG_WDATA,
  input wire I_REG_WR,
  input wire I_REG_RD,
  output reg [`REG_DATA_W-1:0] O_REG_RDATA,
  output reg O_REG_RVALID,
  input wire I_WCLK,
  input wire I_PLAY_STEP_RATE,
  output wire O_LEFT_PLAY_MUTE,
  output wire [`GAIN_W-1:0] O_LEFT_PLAY_ATTEN,
  output wire O_RIGHT_PLAY_MUTE,
  output wire [`GAIN_W-1:0] O_RIGHT_PLAY_ATTEN,
  output wire O_LEFT_PLAY_STEP_DONE,
  output wire O_RIGHT_PLAY_STEP_DONE,
  output wire O_SIDETONE_ACTIVE,
  output wire O_SIDETONE_VALID,
  output wire [`GAIN_W-1:0] O_SIDETONE_GAIN,
  output wire O_SIDETONE_STEP_DONE,
  output reg O_HEADSET_MICROPHONE_IN_SEL,
  output reg O_HANDSET_MICROPHONE_IN_SEL,
  output reg O_AUXILIARY_INPUT_ONE_SEL,
  output reg O_AUXILIARY_INPUT_TWO_SEL,
  output reg O_RECORD_DIFFERENTIAL,
  output reg O_CELLPHONE_TO_RECORD
);
  reg left_play_mute_q;
  reg [`GAIN_W-1:0] left_play_volume_q;
  reg right_play_mute_q;
  reg [`GAIN_W-1:0] right_play_volume_q;
  reg sidetone_mute_q;
  reg [`GAIN_W-1:0] sidetone_gain_q;
  reg [2:0] record_source_select_q;
  reg record_source_enable_q;
  reg cellphone_to_record_q;
  reg [`REG_DATA_W-1:0] rdata_d;
  wire tick_fast;
  wire tick_play;
  wire [`GAIN_W-1:0] sidetone_target;
  wire sidetone_step_done;

  // register writes; only the defined fields are stored
  always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      left_play_mute_q <= `RST_PLAY_MUTE;
      left_play_volume_q <= `RST_PLAY_VOL;
      right_play_mute_q <= `RST_PLAY_MUTE;
      right_play_volume_q <= `RST_PLAY_VOL;
      sidetone_mute_q <= `RST_ST_MUTE; // [RULE5]
      sidetone_gain_q <= `RST_ST_GAIN; // [RULE6]
      record_source_select_q <= `RST_SEL;
      record_source_enable_q <= `RST_REC_EN;
      cellphone_to_record_q <= `RST_CELL; // [RULE12]
    end else if (I_REG_WR) begin
      if (I_REG_ADDR == `ADDR_PLAY_GAIN) begin
        left_play_mute_q <= I_REG_WDATA[`PLAY_LEFT_MUTE_BIT]; // [RULE1]
        left_play_volume_q <= I_REG_WDATA[`PLAY_LEFT_VOL_HI:`PLAY_LEFT_VOL_LO]; // [RULE2]
        right_play_mute_q <= I_REG_WDATA[`PLAY_RIGHT_MUTE_BIT]; // [RULE3]
        right_play_volume_q <= I_REG_WDATA[`PLAY_RIGHT_VOL_HI:`PLAY_RIGHT_VOL_LO]; // [RULE4]
      end else if (I_REG_ADDR == `ADDR_MIX_ROUTE) begin
        // bits 2:0 are reserved or read-only and are dropped here
        sidetone_mute_q <= I_REG_WDATA[`MIX_ST_MUTE_BIT]; // [RULE16]
        sidetone_gain_q <= I_REG_WDATA[`MIX_ST_GAIN_HI:`MIX_ST_GAIN_LO];
        record_source_select_q <= I_REG_WDATA[`MIX_SEL_HI:`MIX_SEL_LO];
        record_source_enable_q <= I_REG_WDATA[`MIX_REC_EN_BIT];
        cellphone_to_record_q <= I_REG_WDATA[`MIX_CELL_BIT];
      end
    end
  end

  // readback; unmapped addresses and reserved bits return zero
  always @* begin
    rdata_d = {`REG_DATA_W{1'b0}};
    if (I_REG_ADDR == `ADDR_PLAY_GAIN) begin
      rdata_d[`PLAY_LEFT_MUTE_BIT] = left_play_mute_q;
      rdata_d[`PLAY_LEFT_VOL_HI:`PLAY_LEFT_VOL_LO] = left_play_volume_q;
      rdata_d[`PLAY_RIGHT_MUTE_BIT] = right_play_mute_q;
      rdata_d[`PLAY_RIGHT_VOL_HI:`PLAY_RIGHT_VOL_LO] = right_play_volume_q;
    end else if (I_REG_ADDR == `ADDR_MIX_ROUTE) begin
      rdata_d[`MIX_ST_MUTE_BIT] = sidetone_mute_q;
      rdata_d[`MIX_ST_GAIN_HI:`MIX_ST_GAIN_LO] = sidetone_gain_q;
      rdata_d[`MIX_SEL_HI:`MIX_SEL_LO] = record_source_select_q;
      rdata_d[`MIX_REC_EN_BIT] = record_source_enable_q;
      rdata_d[`MIX_CELL_BIT] = cellphone_to_record_q;
      rdata_d[`MIX_ST_DONE_BIT] = sidetone_step_done; // [RULE13] [RULE16]
    end
  end

  always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_REG_RDATA <= {`REG_DATA_W{1'b0}};
      O_REG_RVALID <= 1'b0;
    end else begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD) begin
        O_REG_RDATA <= rdata_d;
      end
    end
  end

  wclk_tick u_tick (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_wclk(I_WCLK),
    .i_slow(I_PLAY_STEP_RATE),
    .o_tick_fast(tick_fast),
    .o_tick_play(tick_play)
  );

  // attenuation codes count 0.5 dB each, so the code walks by one per step
  gain_stepper #(.W(`GAIN_W), .INIT(`RST_PLAY_VOL)) u_left (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_step(tick_play), // [RULE14]
    .i_target(left_play_volume_q),
    .o_applied(O_LEFT_PLAY_ATTEN), // [RULE2]
    .o_done(O_LEFT_PLAY_STEP_DONE) // [RULE15]
  );

  gain_stepper #(.W(`GAIN_W), .INIT(`RST_PLAY_VOL)) u_right (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_step(tick_play), // [RULE14]
    .i_target(right_play_volume_q),
    .o_applied(O_RIGHT_PLAY_ATTEN), // [RULE4]
    .o_done(O_RIGHT_PLAY_STEP_DONE) // [RULE15]
  );

  // codes past 12 dB all mean 12 dB, so the ramp stops there
  assign sidetone_target = (sidetone_gain_q > `ST_GAIN_MAX) ? `ST_GAIN_MAX :
                           sidetone_gain_q; // [RULE7]

  gain_stepper #(.W(`GAIN_W), .INIT(`RST_ST_GAIN)) u_side (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_step(tick_fast), // [RULE17]
    .i_target(sidetone_target),
    .o_applied(O_SIDETONE_GAIN), // [RULE6]
    .o_done(sidetone_step_done) // [RULE13]
  );

  assign O_SIDETONE_STEP_DONE = sidetone_step_done;
  assign O_LEFT_PLAY_MUTE = left_play_mute_q; // [RULE1]
  assign O_RIGHT_PLAY_MUTE = right_play_mute_q; // [RULE3]
  assign O_SIDETONE_VALID = ~record_source_select_q[2]; // [RULE10]
  assign O_SIDETONE_ACTIVE = ~sidetone_mute_q & ~record_source_select_q[2]; // [RULE5] [RULE10]

  // routing decode is registered so the analog switches see no decode glitches
  always @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      O_HEADSET_MICROPHONE_IN_SEL <= 1'b0;
      O_HANDSET_MICROPHONE_IN_SEL <= 1'b0;
      O_AUXILIARY_INPUT_ONE_SEL <= 1'b0;
      O_AUXILIARY_INPUT_TWO_SEL <= 1'b0;
      O_RECORD_DIFFERENTIAL <= 1'b0;
      O_CELLPHONE_TO_RECORD <= 1'b0;
    end else begin
      O_CELLPHONE_TO_RECORD <= cellphone_to_record_q; // [RULE12]
      O_RECORD_DIFFERENTIAL <= record_source_enable_q & record_source_select_q[2];
      O_HEADSET_MICROPHONE_IN_SEL <= 1'b0;
      O_HANDSET_MICROPHONE_IN_SEL <= 1'b0;
      O_AUXILIARY_INPUT_ONE_SEL <= 1'b0;
      O_AUXILIARY_INPUT_TWO_SEL <= 1'b0;
      if (record_source_enable_q) begin // [RULE11]
        case (record_source_select_q)
          3'h0: O_HEADSET_MICROPHONE_IN_SEL <= 1'b1; // [RULE8]
          3'h1: O_HANDSET_MICROPHONE_IN_SEL <= 1'b1;
          3'h2: O_AUXILIARY_INPUT_ONE_SEL <= 1'b1;
          3'h3: O_AUXILIARY_INPUT_TWO_SEL <= 1'b1;
          3'h4: begin // [RULE9]
            O_HEADSET_MICROPHONE_IN_SEL <= 1'b1;
            O_AUXILIARY_INPUT_ONE_SEL <= 1'b1;
          end
          3'h5: begin
            O_HEADSET_MICROPHONE_IN_SEL <= 1'b1;
            O_AUXILIARY_INPUT_TWO_SEL <= 1'b1;
          end
          3'h6: begin
            O_HANDSET_MICROPHONE_IN_SEL <= 1'b1;
            O_AUXILIARY_INPUT_ONE_SEL <= 1'b1;
          end
          default: begin
            O_HANDSET_MICROPHONE_IN_SEL <= 1'b1;
            O_AUXILIARY_INPUT_TWO_SEL <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ==== codec_gain_regs_checker.sv ====
// port checker for the gain/routing bank
// assumes it is bound onto codec_gain_regs, one clock domain
`timescale 1ns/10ps
module codec_gain_regs_checker (
  input wire I_SYS_CLK,
  input wire I_RST,
  input wire [3:0] I_REG_ADDR,
  input wire [15:0] I_REG_WDATA,
  input wire I_REG_WR,
  input wire I_REG_RD,
  input wire [15:0] O_REG_RDATA,
  input wire O_REG_RVALID,
  input wire O_LEFT_PLAY_MUTE,
  input wire O_RIGHT_PLAY_MUTE,
  input wire [6:0] O_LEFT_PLAY_ATTEN,
  input wire O_SIDETONE_ACTIVE,
  input wire O_SIDETONE_VALID,
  input wire [6:0] O_SIDETONE_GAIN,
  input wire O_SIDETONE_STEP_DONE,
  input wire O_RECORD_DIFFERENTIAL,
  input wire O_CELLPHONE_TO_RECORD
);
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  wire w2 = I_REG_WR && I_REG_ADDR == 4'h2;
  wire w3 = I_REG_WR && I_REG_ADDR == 4'h3;
  chk_left_mute: assert property (w2 |=> O_LEFT_PLAY_MUTE == $past(I_REG_WDATA[15]))
    else $error("left mute not taken from write");
  chk_right_mute: assert property (w2 |=> O_RIGHT_PLAY_MUTE == $past(I_REG_WDATA[7]))
    else $error("right mute not taken from write");
  chk_st_active: assert property (w3 |=>
    O_SIDETONE_ACTIVE == !$past(I_REG_WDATA[15] | I_REG_WDATA[7]))
    else $error("sidetone active wrong after write");
  chk_st_valid: assert property (!O_SIDETONE_VALID |-> !O_SIDETONE_ACTIVE)
    else $error("sidetone active on differential input");
  chk_st_clamp: assert property (O_SIDETONE_GAIN <= 7'h5d)
    else $error("sidetone gain above clamp");
  // reset may drop the gain to its reset code, so the edge just after it is skipped
  chk_st_step: assert property (!$past(I_RST) && !$stable(O_SIDETONE_GAIN) |->
    O_SIDETONE_GAIN == $past(O_SIDETONE_GAIN) + 7'h01 ||
    O_SIDETONE_GAIN + 7'h01 == $past(O_SIDETONE_GAIN))
    else $error("sidetone gain jumped");
  chk_left_step: assert property (!$past(I_RST) && !$stable(O_LEFT_PLAY_ATTEN) |->
    O_LEFT_PLAY_ATTEN == $past(O_LEFT_PLAY_ATTEN) + 7'h01 ||
    O_LEFT_PLAY_ATTEN + 7'h01 == $past(O_LEFT_PLAY_ATTEN))
    else $error("left attenuation jumped");
  chk_done_read: assert property (O_REG_RVALID &&
    $past(I_REG_RD && I_REG_ADDR == 4'h3) |->
    O_REG_RDATA[2:0] == {2'b00, $past(O_SIDETONE_STEP_DONE)})
    else $error("mixer read low bits wrong");
  chk_cell_route: assert property (w3 |=> ##1
    O_CELLPHONE_TO_RECORD == $past(I_REG_WDATA[3], 2))
    else $error("cellphone routing not applied");
  chk_diff_route: assert property (w3 |=> ##1
    O_RECORD_DIFFERENTIAL == $past(I_REG_WDATA[7] & I_REG_WDATA[4], 2))
    else $error("differential routing wrong");
  cover property (w3 && I_REG_WDATA[7]);
  cover property (O_SIDETONE_GAIN == 7'h5d);
  cover property (O_REG_RVALID && O_REG_RDATA[0]);
endmodule
bind codec_gain_regs codec_gain_regs_checker u_chk (.*);

// ==== host_model.sv ====
// host processor model issuing single-cycle register writes and reads
// assumes read data comes with RVALID one cycle after the read edge
`timescale 1ns/10ps
module host_model (
  input wire i_clk,
  input wire i_rvalid,
  input wire [15:0] i_rdata,
  output reg [3:0] o_addr = 4'h0,
  output reg [15:0] o_wdata = 16'h0,
  output reg o_wr = 1'b0,
  output reg o_rd = 1'b0
);
  // a released bus shows the inverse, so sampling it unstrobed shows up
  task wr(input [3:0] a, input [15:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask
  task rd(input [3:0] a, output [15:0] d, output ok);
    @(posedge i_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    @(negedge i_clk);
    ok = i_rvalid;
    d = i_rdata;
  endtask
endmodule

// ==== codec_gain_regs_tb.sv ====
// self-checking bench: host model, word clock pulses, reference of stepping
// assumes design, host model and checker compile alongside
`timescale 1ns/10ps
module codec_gain_regs_tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg wclk = 1'b0;
  reg rate = 1'b0;
  reg [31:0] seed = 32'h182f;
  integer n_fail = 0;
  integer compares = 0;
  integer r, k;
  reg [15:0] d2, d3, q;
  reg ok;
  reg [6:0] la = 7'h7f, ra = 7'h7f, sa = 7'h45;
  wire [3:0] ad;
  wire [15:0] wd, rdat;
  wire wr, rd, rv, lm, rm, lpd, rpd, sact, sval, sd, hed, hnd, ax1, ax2, dif, cel;
  wire [6:0] lat, rat, sg;
  always #4 clk = ~clk;
  host_model u_host (.i_clk(clk), .i_rvalid(rv), .i_rdata(rdat), .o_addr(ad),
    .o_wdata(wd), .o_wr(wr), .o_rd(rd));
  codec_gain_regs u_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_REG_ADDR(ad), .I_REG_WDATA(wd),
    .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdat), .O_REG_RVALID(rv), .I_WCLK(wclk),
    .I_PLAY_STEP_RATE(rate), .O_LEFT_PLAY_MUTE(lm), .O_LEFT_PLAY_ATTEN(lat),
    .O_RIGHT_PLAY_MUTE(rm), .O_RIGHT_PLAY_ATTEN(rat), .O_LEFT_PLAY_STEP_DONE(lpd),
    .O_RIGHT_PLAY_STEP_DONE(rpd), .O_SIDETONE_ACTIVE(sact), .O_SIDETONE_VALID(sval),
    .O_SIDETONE_GAIN(sg), .O_SIDETONE_STEP_DONE(sd), .O_HEADSET_MICROPHONE_IN_SEL(hed),
    .O_HANDSET_MICROPHONE_IN_SEL(hnd), .O_AUXILIARY_INPUT_ONE_SEL(ax1),
    .O_AUXILIARY_INPUT_TWO_SEL(ax2), .O_RECORD_DIFFERENTIAL(dif), .O_CELLPHONE_TO_RECORD(cel));
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [6:0] stp(input [6:0] a, input [6:0] t);
    stp = (a < t) ? a + 7'h01 : (a > t) ? a - 7'h01 : a;
  endfunction
  function [6:0] lim(input [6:0] g);
    lim = (g > 7'h5d) ? 7'h5d : g;
  endfunction
  function [15:0] route(input [15:0] p, input [15:0] m);
    reg [2:0] s;
    s = m[7:5];
    route = {6'h0, p[15], p[7], !m[15] && !m[7], !m[7], m[4] && (s == 0 || s == 4 || s == 5),
      m[4] && (s == 1 || s > 5), m[4] && (s == 2 || s == 4 || s == 6),
      m[4] && (s == 3 || s == 5 || s == 7), m[4] && s[2], m[3]};
  endfunction
  task chk(input string nm, input [15:0] e, input [15:0] s);
    compares = compares + 1;
    if (s !== e) begin
      n_fail = n_fail + 1;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task wpulse;
    @(posedge clk);
    wclk <= 1'b1;
    repeat (4) @(posedge clk);
    wclk <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task end_sim;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    u_host.rd(4'h2, q, ok);
    chk("reset play", 16'hffff, q);
    u_host.rd(4'h3, q, ok);
    chk("reset mix", 16'hc501, q);
    for (r = 0; r < 8; r = r + 1) begin
      seed = lfsr(seed);
      d2 = (r == 0) ? 16'h7e7c : seed[15:0];
      seed = lfsr(seed);
      // every selector code once; round 1 hits the clamp
      d3 = {(r == 1) ? 8'h7f : seed[15:8], r[2:0], seed[4:0]};
      @(posedge clk);
      rate <= r[0];
      u_host.wr(4'h2, d2);
      u_host.wr(4'h3, d3);
      u_host.rd(4'h2, q, ok);
      chk("play read", d2, q);
      u_host.rd(4'h3, q, ok);
      chk("mix read", {d3[15:3], 2'b00, sa == lim(d3[14:8])}, q);
      chk("rvalid", 16'h1, {15'h0, ok});
      chk("route", route(d2, d3),
        {6'h0, lm, rm, sact, sval, hed, hnd, ax1, ax2, dif, cel});
      wpulse;
      wpulse;
      sa = stp(stp(sa, lim(d3[14:8])), lim(d3[14:8]));
      for (k = r % 2; k < 2; k = k + 1) begin
        la = stp(la, d2[14:8]);
        ra = stp(ra, d2[6:0]);
      end
      chk("atten", {2'b00, la, ra}, {2'b00, lat, rat});
      chk("side", {la == d2[14:8], ra == d2[6:0], sa == lim(d3[14:8]), 6'h0, sa},
        {lpd, rpd, sd, 6'h0, sg});
    end
    // long ramp: without the clamp the gain would walk past its ceiling
    u_host.wr(4'h3, 16'h7f00);
    repeat (100) wpulse;
    chk("clamp", {9'h001, 7'h5d}, {8'h00, sd, sg});
    u_host.rd(4'h3, q, ok);
    chk("clamp read", 16'h7f01, q);
    u_host.wr(4'h5, 16'hffff);
    u_host.rd(4'h5, q, ok);
    chk("unmapped", 16'h0000, q);
    u_host.rd(4'h2, q, ok);
    chk("play kept", d2, q);
    end_sim;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_fail = n_fail + 1;
    end_sim;
  end
endmodule
